// ==== cantc_pkg.sv ====
// cantc_pkg: shared constants of the transceiver control block.
// assumes a 25 MHz system clock; the parameter defaults of the FIFO, timer and stream interface repeat some of these numbers.
package cantc_pkg;

  // ****************************************************************
  // timebase
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIMEOUT_NS    = 1250000;
  // least time, so round up to whole cycles
  localparam int TIMEOUT_CYC   =
    (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 16;

  // ****************************************************************
  // receive event stream
  // ****************************************************************
  localparam int EVT_W      = 4;
  localparam int EVT_DEPTH  = 8;
  localparam int EVT_BUS    = 0;
  localparam int EVT_DRIVE  = 1;
  localparam int EVT_MODE   = 2;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic RST_TXD  = 1'h1;
  localparam logic RST_RXD  = 1'h1;

  // ****************************************************************
  // modes and supply states
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_FAST    = 2'b00,
    MODE_SLOPE   = 2'b01,
    MODE_STANDBY = 2'b10
  } cantc_mode_t;

  typedef enum logic [1:0] {
    PWR_OFF      = 2'b00,
    PWR_WAIT_TXH = 2'b01,
    PWR_ACTIVE   = 2'b10
  } cantc_pwr_t;

endpackage

// ==== cantc_stream_if.sv ====
// cantc_stream_if: valid/ready word stream between the block's modules.
// assumes source and sink share one clock.
`timescale 1ns/100ps
interface cantc_stream_if #(
  parameter int W = 4
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  // producer drives valid and data, consumer drives ready
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== cantc_dom_timer.sv ====
// cantc_dom_timer: counts cycles of a continuous low on transmit data.
// assumes the low flag is already synchronised to i_clk_sys.
`timescale 1ns/100ps
module cantc_dom_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  // control
  input  wire logic [W-1:0] i_limit,
  input  wire logic         i_low,
  // status
  output logic              o_expired
);

  logic [W-1:0] count;

  // saturating count; any high level restarts it from zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || !i_low) begin
      count <= '0;
    end else if (count != i_limit) begin
      count <= count + W'(1);
    end
  end

  // limit reached means the low has lasted longer than the limit
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= i_low && (count == i_limit);
    end
  end

endmodule

// ==== cantc_fifo.sv ====
// cantc_fifo: small synchronous FIFO with valid/ready on both sides.
// assumes one clock; full and empty are exact, no overwrite.
`timescale 1ns/100ps
module cantc_fifo #(
  parameter int W     = 4,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  // streams
  cantc_stream_if.snk in_s,
  cantc_stream_if.src out_s
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   fill;
  logic          push;
  logic          pop;

  // handshakes are combinational so back-pressure reaches the source
  assign in_s.ready  = (fill != (AW+1)'(DEPTH));
  assign out_s.valid = (fill != '0);
  assign out_s.data  = mem[rd_ptr];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  // storage
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  // pointers wrap at depth; depth is kept a power of two
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ==== cantc_core.sv ====
// cantc_core: digital control of a high-speed CAN transceiver.
// assumes analog comparators deliver mode, supply and temperature levels
// as asynchronous pins; the bus wire level is resolved outside from oe.
//
// Function
// (R1) transmit low drives dominant, high leaves recessive
// (R2) other node's dominant overrides our recessive
// (R3) receive output follows resolved bus continuously
// (R4) receive reads zero on foreign dominant bits
// (R5) over-temperature disables only the bus drivers
// (R6) mode pin decodes standby, slope, fast
// (R7) standby keeps transmitter off, receive still works
// (R8) controller may wake transceiver via mode pin
// (R9) long transmit low disables both drivers
// (R10) drivers stay off until transmit rises again
// (R11) controller keeps bit time under the maximum
// (R12) bus stays undriven until supply good
// (R13) low transmit at power-good holds drivers off
// (R14) brown-out returns bus lines to undriven
// (R15) controller stays within maximum bus rate
// (R16) floating transmit input reads as high
// (R17) timeout counter runs on own timebase; the code counts cycles of i_clk_sys instead
`timescale 1ns/100ps
module cantc_core #(
  parameter int P_TIMEOUT_CYC = cantc_pkg::TIMEOUT_CYC,
  parameter int P_EVT_W       = cantc_pkg::EVT_W,
  parameter int P_EVT_DEPTH   = cantc_pkg::EVT_DEPTH
) (
  // clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_resetn,
  // controller side
  input  wire logic               i_txd,
  input  wire logic               i_txd_float,
  output logic                    o_rxd,
  // mode select comparators
  input  wire logic               i_ms_above_hi,
  input  wire logic               i_ms_below_lo,
  // supply and temperature monitors
  input  wire logic               i_por_rise_threshold,
  input  wire logic               i_brownout_threshold,
  input  wire logic               i_overtemp,
  // bus side
  input  wire logic               i_bus_dom_other,
  output logic                    o_canh_o,
  output logic                    o_canh_oe,
  output logic                    o_canl_o,
  output logic                    o_canl_oe,
  // status
  output logic [1:0]              o_mode,
  output logic                    o_slope_limit,
  output logic                    o_drv_enable,
  output logic                    o_timeout,
  output logic                    o_pwr_active,
  // receive event stream
  output logic                    o_evt_valid,
  output logic [P_EVT_W-1:0]      o_evt_data,
  input  wire logic               i_evt_ready,
  output logic                    o_evt_fill_ready,
  output logic                    o_evt_overrun,
  input  wire logic               i_evt_overrun_clr
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************

  logic txd_m;
  logic txd_s;
  logic flt_m;
  logic flt_s;
  logic hi_m;
  logic hi_s;
  logic lo_m;
  logic lo_s;
  logic por_m;
  logic por_s;
  logic bo_m;
  logic bo_s;
  logic ot_m;
  logic ot_s;
  logic oth_m;
  logic oth_s;

  // two flops per pin; the first stage feeds only the second
  // transmit resets high, as the pull-up would show it [R16]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      txd_m <= cantc_pkg::RST_TXD;
      txd_s <= cantc_pkg::RST_TXD;
      flt_m <= 1'b0;
      flt_s <= 1'b0;
    end else begin
      txd_m <= i_txd;
      txd_s <= txd_m;
      flt_m <= i_txd_float;
      flt_s <= flt_m;
    end
  end

  // mode comparators
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      hi_m <= 1'b0;
      hi_s <= 1'b0;
      lo_m <= 1'b0;
      lo_s <= 1'b0;
    end else begin
      hi_m <= i_ms_above_hi;
      hi_s <= hi_m;
      lo_m <= i_ms_below_lo;
      lo_s <= lo_m;
    end
  end

  // supply, temperature and foreign bus level
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      por_m <= 1'b0;
      por_s <= 1'b0;
      bo_m  <= 1'b1;
      bo_s  <= 1'b1;
      ot_m  <= 1'b0;
      ot_s  <= 1'b0;
      oth_m <= 1'b0;
      oth_s <= 1'b0;
    end else begin
      por_m <= i_por_rise_threshold;
      por_s <= por_m;
      bo_m  <= i_brownout_threshold;
      bo_s  <= bo_m;
      ot_m  <= i_overtemp;
      ot_s  <= ot_m;
      oth_m <= i_bus_dom_other;
      oth_s <= oth_m;
    end
  end

  // ****************************************************************
  // transmit level and edge
  // ****************************************************************

  logic tx_high;
  logic tx_high_d;
  logic tx_rise;

  // an unconnected pin counts as high, hence recessive [R16]
  assign tx_high = txd_s || flt_s;

  // previous level for the rising-edge test
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      tx_high_d <= cantc_pkg::RST_TXD;
    end else begin
      tx_high_d <= tx_high;
    end
  end

  assign tx_rise = tx_high && !tx_high_d;

  // ****************************************************************
  // mode decode
  // ****************************************************************

  cantc_pkg::cantc_mode_t mode;
  cantc_pkg::cantc_mode_t next_mode;

  // high wins over low: a contradictory pair stays safe in standby
  always_comb begin
    if (hi_s) begin
      next_mode = cantc_pkg::MODE_STANDBY;  // [R6]
    end else if (lo_s) begin
      next_mode = cantc_pkg::MODE_FAST;     // [R6]
    end else begin
      next_mode = cantc_pkg::MODE_SLOPE;    // [R6]
    end
  end

  // leaving standby is just a mode pin change [R8]
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      mode <= cantc_pkg::MODE_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************************************
  // supply gating
  // ****************************************************************

  cantc_pkg::cantc_pwr_t pwr;
  cantc_pkg::cantc_pwr_t next_pwr;

  // power-on waits for supply good and then for a high transmit level
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      cantc_pkg::PWR_OFF: begin
        if (por_s && !bo_s) begin
          if (tx_high) begin
            next_pwr = cantc_pkg::PWR_ACTIVE;    // [R12]
          end else begin
            next_pwr = cantc_pkg::PWR_WAIT_TXH;  // [R13]
          end
        end
      end
      cantc_pkg::PWR_WAIT_TXH: begin
        if (bo_s) begin
          next_pwr = cantc_pkg::PWR_OFF;         // [R14]
        end else if (tx_high) begin
          next_pwr = cantc_pkg::PWR_ACTIVE;      // [R13]
        end
      end
      cantc_pkg::PWR_ACTIVE: begin
        if (bo_s) begin
          next_pwr = cantc_pkg::PWR_OFF;         // [R14]
        end
      end
      default: begin
        next_pwr = cantc_pkg::PWR_OFF;
      end
    endcase
  end

  // reset is the power-on condition, so start undriven
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pwr <= cantc_pkg::PWR_OFF;
    end else begin
      pwr <= next_pwr;
    end
  end

  // ****************************************************************
  // permanent-dominant timeout
  // ****************************************************************

  logic expired;
  logic timeout;

  // counter on the system clock; limit is the least timeout [R17]
  cantc_dom_timer #(
    .W (cantc_pkg::TIMER_W)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_limit   (cantc_pkg::TIMER_W'(P_TIMEOUT_CYC)),
    .i_low     (!tx_high),
    .o_expired (expired)
  );

  // latch the trip; only a rising transmit edge releases it
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      timeout <= 1'b0;
    end else if (tx_rise) begin
      timeout <= 1'b0;                       // [R10]
    end else if (expired) begin
      timeout <= 1'b1;                       // [R9]
    end
  end

  // ****************************************************************
  // bus drivers
  // ****************************************************************

  logic drv_en;
  logic drive_dom;

  // overheating drops only the drivers, receive keeps running [R5]
  assign drv_en = (pwr == cantc_pkg::PWR_ACTIVE)           // [R12]
               && !timeout                                 // [R9]
               && !ot_s                                    // [R5]
               && (mode != cantc_pkg::MODE_STANDBY);       // [R7]

  // dominant only on a low transmit level [R1]
  assign drive_dom = drv_en && !tx_high;

  // both lines switch together; recessive means both undriven
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_canh_oe <= 1'b0;
      o_canl_oe <= 1'b0;
    end else begin
      o_canh_oe <= drive_dom;                // [R1]
      o_canl_oe <= drive_dom;                // [R1]
    end
  end

  // when enabled, high line pulls up and low line pulls down
  assign o_canh_o = 1'b1;
  assign o_canl_o = 1'b0;

  // ****************************************************************
  // receive path
  // ****************************************************************

  logic bus_dom;
  logic bus_dom_d;

  // wired-dominant: any driver makes the bus dominant [R2]
  assign bus_dom = o_canh_oe || oth_s;

  // low while dominant, also in standby and for foreign bits
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_rxd     <= cantc_pkg::RST_RXD;
      bus_dom_d <= 1'b0;
    end else begin
      o_rxd     <= !bus_dom;                 // [R3] [R4]
      bus_dom_d <= bus_dom;
    end
  end

  // ****************************************************************
  // bus event buffer
  // ****************************************************************

  cantc_stream_if #(.W(P_EVT_W)) evt_in ();
  cantc_stream_if #(.W(P_EVT_W)) evt_out ();

  // one word per bus level change, with drive and mode context
  always_comb begin
    evt_in.data = '0;
    evt_in.data[cantc_pkg::EVT_BUS]   = bus_dom;
    evt_in.data[cantc_pkg::EVT_DRIVE] = o_canh_oe;
    evt_in.data[cantc_pkg::EVT_MODE +: 2] = mode;
  end
  assign evt_in.valid = (bus_dom != bus_dom_d);

  cantc_fifo #(
    .W     (P_EVT_W),
    .DEPTH (P_EVT_DEPTH)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .in_s      (evt_in),
    .out_s     (evt_out)
  );

  assign o_evt_valid      = evt_out.valid;
  assign o_evt_data       = evt_out.data;
  assign evt_out.ready    = i_evt_ready;
  assign o_evt_fill_ready = evt_in.ready;

  // events are never held back: a full buffer drops them and says so
  // a new loss in the clear cycle wins over the clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_evt_overrun <= 1'b0;
    end else if (evt_in.valid && !evt_in.ready) begin
      o_evt_overrun <= 1'b1;
    end else if (i_evt_overrun_clr) begin
      o_evt_overrun <= 1'b0;
    end
  end

  // ****************************************************************
  // status
  // ****************************************************************

  // registered copies so status never glitches
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_mode        <= cantc_pkg::MODE_STANDBY;
      o_slope_limit <= 1'b0;
      o_drv_enable  <= 1'b0;
      o_timeout     <= 1'b0;
      o_pwr_active  <= 1'b0;
    end else begin
      o_mode        <= mode;
      o_slope_limit <= (mode == cantc_pkg::MODE_SLOPE);  // [R6]
      o_drv_enable  <= drv_en;
      o_timeout     <= timeout;
      o_pwr_active  <= (pwr == cantc_pkg::PWR_ACTIVE);
    end
  end

endmodule

// ==== cantc_core_monitor.sv ====
// cantc_core_monitor: concurrent checks on the transceiver core's pins.
// assumes it is bound onto cantc_core and sees its ports only.
`timescale 1ns/100ps
module cantc_core_monitor #(
  parameter int P_TIMEOUT_CYC = 20
) (
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_resetn,
  // inputs watched
  input wire logic       i_txd,
  input wire logic       i_txd_float,
  input wire logic       i_overtemp,
  input wire logic       i_brownout_threshold,
  input wire logic       i_bus_dom_other,
  // outputs watched
  input wire logic       o_rxd,
  input wire logic       o_canh_o,
  input wire logic       o_canh_oe,
  input wire logic       o_canl_o,
  input wire logic       o_canl_oe,
  input wire logic [1:0] o_mode,
  input wire logic       o_timeout,
  input wire logic       o_pwr_active
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  // ****************************************************************
  // run length of transmit low
  // ****************************************************************
  // saturates so a long hold never wraps back under the limit
  int low_cnt;
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || i_txd || i_txd_float) begin
      low_cnt <= 0;
    end else if (low_cnt < P_TIMEOUT_CYC + 16) begin
      low_cnt <= low_cnt + 1;
    end
  end

  sequence s_standby; (o_mode == 2'b10)[*3]; endsequence
  sequence s_held_trip; (!i_txd && !i_txd_float)[*4] ##0 o_timeout;
  endsequence

  property p_pair;
    o_canl_oe == o_canh_oe && o_canh_o && !o_canl_o;
  endproperty
  a_pair: assert property (p_pair)
    else $error("line drives not paired");
  property p_recessive; (i_txd && !i_txd_float)[*5] |-> !o_canh_oe;
  endproperty
  a_recessive: assert property (p_recessive)
    else $error("bus driven while transmit high");
  property p_rxd_own; o_canh_oe |=> !o_rxd; endproperty
  a_rxd_own: assert property (p_rxd_own)
    else $error("receive high while own drive on");
  property p_rxd_rec;
    (!i_bus_dom_other && !o_canh_oe)[*4] |-> o_rxd;
  endproperty
  a_rxd_rec: assert property (p_rxd_rec)
    else $error("receive low on recessive bus");
  property p_rxd_foreign; i_bus_dom_other[*4] |-> !o_rxd; endproperty
  a_rxd_foreign: assert property (p_rxd_foreign)
    else $error("receive high on foreign dominant");
  property p_overtemp; i_overtemp[*5] |-> !o_canh_oe; endproperty
  a_overtemp: assert property (p_overtemp)
    else $error("drive on while over temperature");
  property p_standby; s_standby |-> !o_canh_oe; endproperty
  a_standby: assert property (p_standby)
    else $error("drive on in standby");
  property p_trip_late;
    low_cnt == P_TIMEOUT_CYC + 8 |-> o_timeout && !o_canh_oe;
  endproperty
  a_trip_late: assert property (p_trip_late)
    else $error("long transmit low did not trip");
  property p_trip_early; $rose(o_timeout) |-> low_cnt >= P_TIMEOUT_CYC;
  endproperty
  a_trip_early: assert property (p_trip_early)
    else $error("trip before the limit");
  property p_trip_hold; s_held_trip |=> o_timeout; endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip released while transmit low");
  property p_brownout;
    i_brownout_threshold[*5] |-> !o_pwr_active && !o_canh_oe;
  endproperty
  a_brownout: assert property (p_brownout)
    else $error("drive or supply state on in brown-out");
endmodule

// ==== cantc_peer.sv ====
// cantc_peer: another bus node sending eight bits, first bit leftmost.
// assumes the shared system clock; idles recessive.
`timescale 1ns/100ps
module cantc_peer #(
  parameter int P_BIT_CYC = 25
) (
  // clock and control
  input  wire logic       i_clk_sys,
  input  wire logic       i_start,
  input  wire logic [7:0] i_bits,
  // bus side
  output logic            o_dom,
  output logic            o_busy
);
  initial begin
    o_dom  = 1'b0;
    o_busy = 1'b0;
  end

  // ****************************************************************
  // bit sender
  // ****************************************************************
  // starts seen while busy are ignored; caller holds i_bits meanwhile
  always @(posedge i_clk_sys) begin
    if (i_start) begin
      o_busy <= 1'b1;
      for (int i = 7; i >= 0; i--) begin
        o_dom <= !i_bits[i]; // a zero bit pulls the bus dominant
        repeat (P_BIT_CYC) @(posedge i_clk_sys); // 1 Mb/s
      end
      o_dom  <= 1'b0;
      o_busy <= 1'b0;
    end
  end
endmodule

// ==== test_cantc_core.sv ====
// test_cantc_core: self-checking bench for the transceiver core.
// assumes a short trip limit so a timeout fits in a brief run.
`timescale 1ns/100ps
module test_cantc_core;
  localparam int P_TO = 20;
  logic        i_clk_sys, i_resetn, i_txd, i_txd_float, i_overtemp;
  logic        i_ms_above_hi, i_ms_below_lo, i_evt_ready;
  logic        i_por_rise_threshold, i_brownout_threshold;
  logic        i_evt_overrun_clr, peer_start, peer_busy, dom_other;
  logic        o_rxd, o_canh_o, o_canh_oe, o_canl_o, o_canl_oe;
  logic        o_slope_limit, o_drv_enable, o_timeout, o_pwr_active;
  logic        o_evt_valid, o_evt_fill_ready, o_evt_overrun;
  logic [1:0]  o_mode;
  logic [1:0]  mtab [4] = '{2'b01, 2'b00, 2'b10, 2'b10};
  logic [3:0]  o_evt_data;
  logic [7:0]  peer_bits;
  logic [31:0] seed = 32'h43861158;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;
  int          expq[$];

  cantc_core #(.P_TIMEOUT_CYC(P_TO)) cantc_core_i (
    .i_clk_sys, .i_resetn, .i_txd, .i_txd_float, .o_rxd,
    .i_ms_above_hi, .i_ms_below_lo, .i_por_rise_threshold,
    .i_brownout_threshold, .i_overtemp, .i_bus_dom_other(dom_other),
    .o_canh_o, .o_canh_oe, .o_canl_o, .o_canl_oe, .o_mode,
    .o_slope_limit, .o_drv_enable, .o_timeout, .o_pwr_active,
    .o_evt_valid, .o_evt_data, .i_evt_ready, .o_evt_fill_ready,
    .o_evt_overrun, .i_evt_overrun_clr);
  cantc_peer cantc_peer_i (.i_clk_sys, .i_start(peer_start),
    .i_bits(peer_bits), .o_dom(dom_other), .o_busy(peer_busy));

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [3:0] e,
                     input logic [3:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // model: one event word per change of the resolved bus level
  task automatic send(input logic [7:0] b);
    logic d;
    d = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!b[i] != d) expq.push_back(int'(!b[i]));
      d = !b[i];
    end
    if (d) expq.push_back(0);
    while (peer_busy) cyc(1); // the peer ignores a start while busy
    peer_bits  = b;
    peer_start = 1'b1;
    cyc(1);
    peer_start = 1'b0;
  endtask
  // random ready stalls the consumer; a word leaves at the next edge
  task automatic drain(input int n);
    int e;
    repeat (n) begin
      seed = lfsr(seed);
      i_evt_ready = seed[0];
      if (i_evt_ready && o_evt_valid) begin
        e = expq.size() ? expq.pop_front() : 99;
        chk("event word", e[3:0], o_evt_data);
      end
      cyc(1);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a hang is cut short well past the expected run of about 1700 cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {i_txd, i_txd_float, i_ms_above_hi, i_overtemp, peer_start} = '0;
    {i_por_rise_threshold, i_brownout_threshold, i_resetn} = '0;
    {i_evt_overrun_clr, peer_bits} = '0;
    {i_evt_ready, i_ms_below_lo} = 2'b11;
    cyc(10);
    i_resetn = 1'b1;
    cyc(6);
    chk("oe before supply good", 0, 4'(o_canh_oe));
    i_por_rise_threshold = 1'b1;
    cyc(6);
    chk("oe low txd at supply good", 0, 4'(o_canh_oe));
    chk("supply waits for txd", 0, 4'(o_pwr_active));
    i_txd = 1'b1;
    cyc(6);
    chk("supply active", 1, 4'(o_pwr_active));
    i_txd = 1'b0;
    cyc(5);
    chk("oe on dominant", 1, 4'(o_canh_oe));
    chk("rxd on own dominant", 0, 4'(o_rxd));
    i_txd = 1'b1;
    cyc(4);
    $display("power-up test done");
    for (int m = 0; m < 4; m++) begin
      {i_ms_above_hi, i_ms_below_lo} = m[1:0];
      i_txd = 1'b0;
      cyc(6);
      chk("mode", {2'b00, mtab[m]}, {2'b00, o_mode});
      chk("slope flag", 4'(m == 0), 4'(o_slope_limit));
      chk("oe by mode", 4'(m < 2), 4'(o_canh_oe));
      i_txd = 1'b1;
      cyc(4);
    end
    send(8'h00);
    cyc(10);
    chk("rxd foreign in standby", 0, 4'(o_rxd));
    {i_ms_above_hi, i_ms_below_lo} = 2'b01; // wake through mode pin
    cyc(6);
    chk("mode after wake", 0, {2'b00, o_mode});
    chk("rxd foreign awake", 0, 4'(o_rxd));
    cyc(200);
    $display("mode test done");
    i_txd = 1'b0;
    i_overtemp = 1'b1;
    cyc(6);
    chk("oe over temperature", 0, 4'(o_canh_oe));
    chk("rxd over temperature", 1, 4'(o_rxd));
    chk("drive enable over temperature", 0, 4'(o_drv_enable));
    i_overtemp = 1'b0;
    cyc(5);
    chk("oe after cool down", 1, 4'(o_canh_oe));
    chk("drive enable cooled", 1, 4'(o_drv_enable));
    i_txd = 1'b1;
    cyc(4);
    i_txd = 1'b0;
    cyc(P_TO + 10);
    chk("trip flag", 1, 4'(o_timeout));
    chk("oe after trip", 0, 4'(o_canh_oe));
    cyc(30);
    chk("oe held off", 0, 4'(o_canh_oe));
    i_txd = 1'b1;
    cyc(4);
    i_txd = 1'b0;
    cyc(5);
    chk("trip cleared", 0, 4'(o_timeout));
    chk("oe after rise", 1, 4'(o_canh_oe));
    i_txd_float = 1'b1;
    cyc(6);
    chk("oe txd floating", 0, 4'(o_canh_oe));
    i_txd_float = 1'b0;
    i_brownout_threshold = 1'b1;
    cyc(6);
    chk("supply in brown-out", 0, 4'(o_pwr_active));
    chk("oe in brown-out", 0, 4'(o_canh_oe));
    i_txd = 1'b1;
    i_brownout_threshold = 1'b0;
    cyc(6);
    chk("supply after brown-out", 1, 4'(o_pwr_active));
    $display("protection test done");
    i_evt_ready = 1'b1;
    cyc(20);
    i_evt_overrun_clr = 1'b1;
    cyc(1);
    i_evt_overrun_clr = 1'b0;
    chk("queue empty", 0, 4'(o_evt_valid));
    expq.delete();
    i_evt_ready = 1'b0;
    send(8'h55);
    cyc(205);
    send(8'h55);
    cyc(205);
    chk("fill ready when full", 0, 4'(o_evt_fill_ready));
    chk("overrun when full", 1, 4'(o_evt_overrun));
    expq = expq[0:7];
    drain(100);
    chk("words left", 0, 4'(expq.size()));
    i_evt_overrun_clr = 1'b1;
    cyc(1);
    i_evt_overrun_clr = 1'b0;
    chk("overrun cleared", 0, 4'(o_evt_overrun));
    repeat (3) begin
      seed = lfsr(seed);
      send(seed[15:8]);
      drain(260);
    end
    chk("words left", 0, 4'(expq.size()));
    $display("event test done");
    end_of_test();
  end
endmodule

bind cantc_core cantc_core_monitor #(.P_TIMEOUT_CYC(P_TIMEOUT_CYC))
  cantc_core_monitor_i (.i_clk_sys, .i_resetn, .i_txd, .i_txd_float,
    .i_overtemp, .i_brownout_threshold, .i_bus_dom_other, .o_rxd,
    .o_canh_o, .o_canh_oe, .o_canl_o, .o_canl_oe, .o_mode, .o_timeout,
    .o_pwr_active);
